// *** logic/pxp_map.vh ***
`ifndef PXP_MAP_VH
`define PXP_MAP_VH

// ---------------------------------------------------------------
// Management register indices (byte address is four times these)
// ---------------------------------------------------------------
`define PXP_IDX_PAGE_SEL       5'h1f
`define PXP_IDX_SERDES_CTRL    5'h10
`define PXP_IDX_GOOD_CRC       5'h12
`define PXP_IDX_EXT_MODE       5'h13
`define PXP_IDX_UPPER_FIRST    5'h10
`define PXP_IDX_UPPER_LAST     5'h1e

// ---------------------------------------------------------------
// Block-own registers at byte offsets outside the management map
// ---------------------------------------------------------------
`define PXP_ADDR_IRQ_STATUS    8'h80
`define PXP_ADDR_IRQ_MASK      8'h84
`define PXP_ADDR_PORT_CTRL     8'h88

// ---------------------------------------------------------------
// Page codes
// ---------------------------------------------------------------
`define PXP_PAGE_MAIN          16'h0000
`define PXP_PAGE_EXT1          16'h0001

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define PXP_SD_TX_RF_HI        15
`define PXP_SD_TX_RF_LO        14
`define PXP_SD_LP_RF_HI        13
`define PXP_SD_LP_RF_LO        12
`define PXP_SD_ALLOW_1000X     9
`define PXP_SD_ALLOW_100FX     8
`define PXP_SD_FEF             6
`define PXP_CRC_SEEN           15
`define PXP_CRC_CNT_HI         13
`define PXP_EM_LED_HI          15
`define PXP_EM_LED_LO          12
`define PXP_EM_BLINK_SUP       11
`define PXP_EM_FAST_FAIL       4
`define PXP_EM_MDI_HI          3
`define PXP_EM_MDI_LO          2
`define PXP_EM_SD_POL          0
`define PXP_RST_TX_RF          2'h0
`define PXP_RST_EM             16'h0000
`define PXP_CRC_WRAP           14'h270f
`define PXP_MDI_AUTO           2'h0
`define PXP_MDI_RSVD           2'h1
`define PXP_MDI_FORCE          2'h2
`define PXP_MDI_FORCE_X        2'h3
`define PXP_NUM_MEDIA_PORTS    3'h4

// Interrupt status bit positions
`define PXP_IRQ_FEF            0
`define PXP_IRQ_PKT            1
`define PXP_IRQ_WRAP           2

`endif

// *** logic/pxp_crc_counter.v ***
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Good-CRC packet counter, modulo ten thousand, clear on read
// ---------------------------------------------------------------
`include "pxp_map.vh"

module pxp_crc_counter (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_sys_rst,
    // Events
    input  wire        i_good_pkt,
    input  wire        i_rd_clear,
    // State
    output wire [13:0] o_count,
    output wire        o_seen,
    output wire        o_wrap
);

    reg  [13:0] cnt_q;
    reg         seen_q;
    wire [13:0] inc;

    // Wraps, never saturates
    assign inc    = (cnt_q == `PXP_CRC_WRAP) ? 14'h0000 :
                    cnt_q + 14'h0001; // RL12
    assign o_wrap = i_good_pkt && (cnt_q == `PXP_CRC_WRAP);
    assign o_count = cnt_q;
    assign o_seen  = seen_q;

    // A packet in the read cycle counts after the clear, so none is lost
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cnt_q  <= 14'h0000;
            seen_q <= 1'b0;
        end else if (i_rd_clear) begin
            cnt_q  <= i_good_pkt ? 14'h0001 : 14'h0000; // RL12
            seen_q <= i_good_pkt; // RL11
        end else if (i_good_pkt) begin
            cnt_q  <= inc; // RL12
            seen_q <= 1'b1; // RL11
        end
    end

endmodule

// *** logic/pxp_bank.v ***
// Functional notes
// (RL1) Writing 0x0001 to register 31 selects extended page 1 upper space.
// (RL2) Writing 0x0000 to register 31 returns upper addresses to main space.
// (RL3) With page 1 selected, addresses 16-30 reach page 1 registers.
// (RL4) Addresses 0-15 reach the same registers whatever page is selected.
// (RL5) SerDes media settings act only on ports 0 to 3.
// (RL6) Bits 15:14 are writable remote fault code sent, reset 00.
// (RL7) Bits 13:12 report remote fault code received from link partner.
// (RL8) Bit 9, reset 1, allows 1000BASE-X link-up; clear blocks it.
// (RL9) Bit 8, reset 1, allows 100BASE-FX link-up; clear blocks it.
// (RL10) Bit 6 sets on 100BASE-FX far end fault; read clears it.
// (RL11) Good-CRC bit 15 shows a packet since last read; read clears.
// (RL12) Bits 13:0 count good packets modulo 10000, wrap, clear on read.
// (RL13) Bits 15:12 select extended mode for LED3..LED0, reset 0.
// (RL14) Bit 11 set suppresses the LED blink after low-power hold release.
// (RL15) Bit 4 makes shared fast-fail pin the fast link failure output; only port 0 does so here, other ports keep the GPIO.
// (RL16) Bits 3:2: 00 auto, 10 force MDI, 11 force MDI-X, 01 reserved.
// (RL17) Bit 0 sets signal detect polarity: 1 active low, 0 active high.
// (RL18) Retained fields survive a port software reset; hardware reset clears.
// (RL19) Reserved addresses and bits read zero; writes to them are ignored.
`timescale 1ns/1ps

`include "pxp_map.vh"

module pxp_bank (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_sys_rst,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output wire        o_pready,
    output wire        o_pslverr,
    output reg  [31:0] o_prdata,
    // Main register space, reached for 0-15 always and 16-30 on main page
    input  wire [15:0] i_main_rdata,
    output reg         o_main_wr,
    output reg  [4:0]  o_main_idx,
    output reg  [15:0] o_main_wdata,
    // Port identity and soft reset
    input  wire [2:0]  i_port_id,
    input  wire        i_soft_rst,
    // Media and counter events
    input  wire [1:0]  i_lp_remote_fault,
    input  wire        i_fx_far_end_fault,
    input  wire        i_good_crc_pkt,
    // Pins and steering
    input  wire [3:0]  i_signal_detect_input,
    input  wire        i_low_power_hold_input,
    input  wire        i_gpio_out,
    input  wire        i_gpio_oe,
    input  wire        i_fast_link_fail,
    output reg  [1:0]  o_tx_remote_fault,
    output reg         o_allow_1000x,
    output reg         o_allow_100fx,
    output reg  [3:0]  o_led_ext_mode,
    output reg         o_led_blink,
    output reg  [1:0]  o_mdi_mode,
    output reg  [3:0]  o_signal_detect,
    output reg         o_shared_fast_fail_pin_out,
    output reg         o_shared_fast_fail_pin_oe,
    output reg         o_page_ext1,
    output wire        o_irq
);

    // -----------------------------------------------------------
    // Decoding
    // -----------------------------------------------------------
    function is_mgmt;
        input [7:0] a;
        begin
            is_mgmt = (a[7] == 1'b0) && (a[1:0] == 2'b00);
        end
    endfunction

    function is_ext;
        input [4:0] idx;
        input       pg;
        begin
            is_ext = pg && (idx >= `PXP_IDX_UPPER_FIRST) &&
                     (idx <= `PXP_IDX_UPPER_LAST); // RL3 RL4
        end
    endfunction

    wire       acc    = i_psel && i_penable;
    wire       wr     = acc && i_pwrite;
    wire       rd     = acc && !i_pwrite;
    wire [4:0] idx    = i_paddr[6:2];
    wire       mgmt   = is_mgmt(i_paddr);
    wire       ext    = mgmt && is_ext(idx, o_page_ext1);
    wire       media  = (i_port_id < `PXP_NUM_MEDIA_PORTS);
    wire [15:0] wd    = i_pwdata[15:0];
    reg         rd_ack_q;
    wire        rd_first = rd && !rd_ack_q;

    // Reads take one wait state so the registered data stands at the
    // edge where the master samples pready; writes complete at once
    assign o_pready  = i_pwrite || rd_ack_q;
    assign o_pslverr = 1'b0;

    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    reg  [15:0] page_q;
    reg  [1:0]  tx_rf_q;
    reg         allow_1000x_q;
    reg         allow_100fx_q;
    reg         fef_q;
    reg  [15:0] em_q;
    reg  [2:0]  irq_stat_q;
    reg  [2:0]  irq_mask_q;
    reg         hold_q;

    wire [13:0] crc_cnt;
    wire        crc_seen;
    wire        crc_wrap;
    wire        crc_rd = rd_first && ext && (idx == `PXP_IDX_GOOD_CRC);
    wire        sd_rd  = rd_first && ext && (idx == `PXP_IDX_SERDES_CTRL);
    wire        em_wr  = wr && ext && (idx == `PXP_IDX_EXT_MODE);
    wire        sd_wr  = wr && ext && (idx == `PXP_IDX_SERDES_CTRL);

    pxp_crc_counter u_crc (
        .i_sys_clk  (i_sys_clk),
        .i_sys_rst  (i_sys_rst),
        .i_good_pkt (i_good_crc_pkt),
        .i_rd_clear (crc_rd),
        .o_count    (crc_cnt),
        .o_seen     (crc_seen),
        .o_wrap     (crc_wrap)
    );

    // Page select; other page codes are kept but map nothing here
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            page_q <= `PXP_PAGE_MAIN;
        end else if (wr && mgmt && (idx == `PXP_IDX_PAGE_SEL)) begin
            page_q <= wd; // RL1 RL2
        end
    end

    always @* begin
        o_page_ext1 = (page_q == `PXP_PAGE_EXT1); // RL1 RL2
    end

    // Non-sticky transmit fault code falls back on soft reset; the
    // sticky link-up permits and mode bits survive it
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            tx_rf_q       <= `PXP_RST_TX_RF; // RL6
            allow_1000x_q <= 1'b1; // RL8
            allow_100fx_q <= 1'b1; // RL9
            em_q          <= `PXP_RST_EM; // RL13
        end else begin
            if (i_soft_rst) begin
                tx_rf_q <= `PXP_RST_TX_RF; // RL18
            end else if (sd_wr) begin
                tx_rf_q <= wd[`PXP_SD_TX_RF_HI:`PXP_SD_TX_RF_LO]; // RL6
            end
            if (sd_wr) begin
                allow_1000x_q <= wd[`PXP_SD_ALLOW_1000X]; // RL8
                allow_100fx_q <= wd[`PXP_SD_ALLOW_100FX]; // RL9
            end
            if (em_wr) begin
                // Reserved bits 10:5 and 1 stay zero
                em_q <= {wd[15:11], 6'h00, wd[4:2], 1'b0,
                         wd[`PXP_EM_SD_POL]}; // RL13 RL19
            end
        end
    end

    // Far end fault: a new fault wins over the clearing read
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            fef_q <= 1'b0;
        end else if (i_fx_far_end_fault && media) begin
            fef_q <= 1'b1; // RL10
        end else if (sd_rd) begin
            fef_q <= 1'b0; // RL10
        end
    end

    // -----------------------------------------------------------
    // Interrupts
    // -----------------------------------------------------------
    wire [2:0] irq_ev = {crc_wrap, i_good_crc_pkt,
                         i_fx_far_end_fault && media};
    wire       st_wr  = wr && (i_paddr == `PXP_ADDR_IRQ_STATUS);

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
        end else begin
            irq_stat_q <= irq_ev |
                          (irq_stat_q & ~(st_wr ? i_pwdata[2:0] : 3'h0));
            if (wr && (i_paddr == `PXP_ADDR_IRQ_MASK)) begin
                irq_mask_q <= i_pwdata[2:0];
            end
        end
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // -----------------------------------------------------------
    // Read data and main-space forwarding
    // -----------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= rd_first;
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h00000000;
        end else if (rd_first) begin
            o_prdata <= 32'h00000000; // RL19
            if (ext) begin
                case (idx)
                    `PXP_IDX_SERDES_CTRL: o_prdata[15:0] <=
                        {tx_rf_q, i_lp_remote_fault, 2'h0,
                         allow_1000x_q, allow_100fx_q, 1'b0,
                         fef_q, 6'h00}; // RL7
                    `PXP_IDX_GOOD_CRC: o_prdata[15:0] <=
                        {crc_seen, 1'b0, crc_cnt}; // RL11 RL12
                    `PXP_IDX_EXT_MODE: o_prdata[15:0] <= em_q;
                    default: o_prdata[15:0] <= 16'h0000; // RL19
                endcase
            end else if (mgmt && (idx == `PXP_IDX_PAGE_SEL)) begin
                o_prdata[15:0] <= page_q;
            end else if (mgmt) begin
                o_prdata[15:0] <= i_main_rdata; // RL4
            end else if (i_paddr == `PXP_ADDR_IRQ_STATUS) begin
                o_prdata[2:0] <= irq_stat_q;
            end else if (i_paddr == `PXP_ADDR_IRQ_MASK) begin
                o_prdata[2:0] <= irq_mask_q;
            end else if (i_paddr == `PXP_ADDR_PORT_CTRL) begin
                o_prdata[0] <= o_page_ext1;
            end
        end
    end

    always @* begin
        o_main_idx   = idx;
        o_main_wdata = wd;
        o_main_wr    = wr && mgmt && !ext &&
                       (idx != `PXP_IDX_PAGE_SEL); // RL3 RL4
    end

    // -----------------------------------------------------------
    // Steering outputs
    // -----------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= i_low_power_hold_input;
        end
    end

    // SerDes settings only reach the media on ports 0..3; elsewhere they idle
    always @* begin
        o_tx_remote_fault = media ? tx_rf_q : 2'h0; // RL5 RL6
        o_allow_1000x     = media && allow_1000x_q; // RL5 RL8
        o_allow_100fx     = media && allow_100fx_q; // RL5 RL9
        o_led_ext_mode    = em_q[`PXP_EM_LED_HI:`PXP_EM_LED_LO]; // RL13
        o_led_blink       = hold_q && !i_low_power_hold_input &&
                            !em_q[`PXP_EM_BLINK_SUP]; // RL14
        // Reserved crossover code behaves as automatic
        o_mdi_mode        = (em_q[3:2] == `PXP_MDI_RSVD) ? `PXP_MDI_AUTO :
                            em_q[`PXP_EM_MDI_HI:`PXP_EM_MDI_LO]; // RL16
        o_signal_detect   = em_q[`PXP_EM_SD_POL] ?
                            ~i_signal_detect_input :
                            i_signal_detect_input; // RL17
        // Only port 0 owns the shared pin; others leave it to the GPIO
        if (em_q[`PXP_EM_FAST_FAIL] && (i_port_id == 3'h0)) begin
            o_shared_fast_fail_pin_out = i_fast_link_fail; // RL15
            o_shared_fast_fail_pin_oe  = 1'b1; // RL15
        end else begin
            o_shared_fast_fail_pin_out = i_gpio_out; // RL15
            o_shared_fast_fail_pin_oe  = i_gpio_oe; // RL15
        end
    end

endmodule

// *** tb/pxp_bank_monitor.sv ***
`timescale 1ns/1ps
module pxp_bank_monitor (
    // Clock, reset and bus
    input wire        i_sys_clk,
    input wire        i_sys_rst,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [7:0]  i_paddr,
    input wire [31:0] i_pwdata,
    // Port and pins
    input wire [2:0]  i_port_id,
    input wire        i_gpio_out,
    input wire        i_gpio_oe,
    input wire        o_main_wr,
    input wire [4:0]  o_main_idx,
    input wire        o_allow_1000x,
    input wire [1:0]  o_tx_remote_fault,
    input wire [1:0]  o_mdi_mode,
    input wire        o_shared_fast_fail_pin_out,
    input wire        o_shared_fast_fail_pin_oe,
    input wire        o_page_ext1
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    wire acc = i_psel && i_penable;
    wire wr_pg = acc && i_pwrite && i_paddr == 8'h7c;
    wire wr_up = acc && i_pwrite && i_paddr >= 8'h40 && i_paddr <= 8'h78;
    property p_page_on;
        wr_pg && i_pwdata[15:0] == 16'h0001 |=> o_page_ext1;
    endproperty
    property p_page_off;
        wr_pg && i_pwdata[15:0] == 16'h0000 |=> !o_page_ext1;
    endproperty
    // Page flag may only move on a page register write
    property p_page_hold;
        !wr_pg |=> $stable(o_page_ext1);
    endproperty
    property p_upper;
        wr_up && o_page_ext1 |-> !o_main_wr;
    endproperty
    property p_lower;
        acc && i_pwrite && i_paddr < 8'h40 |->
            o_main_wr && o_main_idx == i_paddr[6:2];
    endproperty
    property p_port;
        i_port_id > 3'h3 |-> !o_allow_1000x && o_tx_remote_fault == 2'h0;
    endproperty
    property p_mdi;
        acc ##1 1'b1 |-> o_mdi_mode != 2'h1;
    endproperty
    property p_gpio;
        i_port_id != 3'h0 |-> o_shared_fast_fail_pin_out == i_gpio_out
            && o_shared_fast_fail_pin_oe == i_gpio_oe;
    endproperty
    a_page_on: assert property (p_page_on)
        else $error("page 1 not selected");
    a_page_off: assert property (p_page_off)
        else $error("main page not restored");
    a_page_hold: assert property (p_page_hold)
        else $error("page changed without write");
    a_upper: assert property (p_upper)
        else $error("upper write leaked to main space");
    a_lower: assert property (p_lower)
        else $error("lower write not forwarded");
    a_port: assert property (p_port)
        else $error("media setting on foreign port");
    a_mdi: assert property (p_mdi)
        else $error("reserved crossover code driven");
    a_gpio: assert property (p_gpio)
        else $error("fast fail pin on non zero port");
    c_page: cover property (wr_pg && i_pwdata[0]);
    c_count: cover property (acc && !i_pwrite && i_paddr == 8'h48);
    c_port: cover property (i_port_id > 3'h3);
endmodule

bind pxp_bank pxp_bank_monitor u_mon (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_port_id(i_port_id), .i_gpio_out(i_gpio_out),
    .i_gpio_oe(i_gpio_oe), .o_main_wr(o_main_wr), .o_main_idx(o_main_idx),
    .o_allow_1000x(o_allow_1000x), .o_tx_remote_fault(o_tx_remote_fault),
    .o_mdi_mode(o_mdi_mode),
    .o_shared_fast_fail_pin_out(o_shared_fast_fail_pin_out),
    .o_shared_fast_fail_pin_oe(o_shared_fast_fail_pin_oe),
    .o_page_ext1(o_page_ext1));

// *** tb/pxp_main_space_model.sv ***
`timescale 1ns/1ps
module pxp_main_space_model (
    // Clock and main space access
    input  wire        i_sys_clk,
    input  wire        i_wr,
    input  wire [4:0]  i_idx,
    input  wire [15:0] i_wdata,
    output wire [15:0] o_rdata
);
    reg     [15:0] mem_q [0:31];
    integer        i;
    // Unwritten words hold a pattern, not zero, so stray reads show
    initial begin
        for (i = 0; i < 32; i = i + 1) begin
            mem_q[i] = ~i[15:0];
        end
    end
    always @(posedge i_sys_clk) begin
        if (i_wr) begin
            mem_q[i_idx] <= i_wdata;
        end
    end
    assign o_rdata = mem_q[i_idx];
endmodule

// *** tb/pxp_bank_tb.sv ***
`timescale 1ns/1ps
module pxp_bank_tb;
    reg clk = 1'b0, rst = 1'b1, psel = 0, pen = 0, pwr = 0, srst = 0;
    reg [7:0] addr = 0;
    reg [31:0] wd = 0;
    reg [2:0] port = 0;
    reg [1:0] lprf = 0;
    reg fef = 0, pkt = 0, hold = 0, gout = 0, goe = 0, ffl = 0;
    reg [3:0] sdi = 0;
    wire [31:0] prdata;
    wire [15:0] mrd, mwd;
    wire [4:0] midx;
    wire [3:0] ledm, sdo;
    wire [1:0] txrf, mdi;
    wire pready, mwr, a1k, a100, blink, pin_o, pin_oe, pg;
    int failures = 0, n_tests = 0, cyc = 0, k, n, nb;
    logic [15:0] v;
    logic [31:0] q;
    logic [1:0] mk;
    pxp_bank dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
        .o_pready(pready), .o_pslverr(), .o_prdata(prdata),
        .i_main_rdata(mrd), .o_main_wr(mwr), .o_main_idx(midx),
        .o_main_wdata(mwd), .i_port_id(port), .i_soft_rst(srst),
        .i_lp_remote_fault(lprf), .i_fx_far_end_fault(fef),
        .i_good_crc_pkt(pkt), .i_signal_detect_input(sdi),
        .i_low_power_hold_input(hold), .i_gpio_out(gout), .i_gpio_oe(goe),
        .i_fast_link_fail(ffl), .o_tx_remote_fault(txrf),
        .o_allow_1000x(a1k), .o_allow_100fx(a100), .o_led_ext_mode(ledm),
        .o_led_blink(blink), .o_mdi_mode(mdi), .o_signal_detect(sdo),
        .o_shared_fast_fail_pin_out(pin_o),
        .o_shared_fast_fail_pin_oe(pin_oe), .o_page_ext1(pg), .o_irq());
    pxp_main_space_model u_main (.i_sys_clk(clk), .i_wr(mwr),
        .i_idx(midx), .i_wdata(mwd), .o_rdata(mrd));
    always #50 clk = ~clk;
    // Timeout sized for ten thousand packets plus bus traffic
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end
    task report_and_stop;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read data is taken at the edge where pready is sampled high
    task apb(input w, input [7:0] a, input [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input [7:0] a, input [15:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        apb(1'b0, a, 16'h0000);
        chk(q, e);
    endtask
    task pulse(input int c);
        @(posedge clk);
        pkt <= 1'b1;
        repeat (c) @(posedge clk);
        pkt <= 1'b0;
    endtask
    task blinks(input [15:0] m);
        wr(8'h4c, m);
        hold <= 1'b1;
        @(posedge clk);
        hold <= 1'b0;
        nb = 0;
        repeat (4) @(posedge clk) nb = nb + blink;
    endtask
    initial begin
        void'($urandom(32'h3d0f));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wr(8'h7c, 16'h0001);
        chk(pg, 1);
        for (k = 0; k < 4; k++) begin
            lprf <= k[1:0];
            rd(8'h40, 32'h0300 | (k << 12));
        end
        lprf <= 2'h0;
        rd(8'h44, 0);
        rd(8'h4c, 0);
        wr(8'h40, 16'hffff);
        rd(8'h40, 32'hc300);
        wr(8'h40, 16'h4000);
        chk({txrf, a1k, a100}, 4'h4);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd(8'h40, 0);
        port <= 3'h5;
        wr(8'h40, 16'hc300);
        chk({txrf, a1k, a100}, 0);
        port <= 3'h0;
        @(posedge clk);
        chk({txrf, a1k, a100}, 4'hf);
        $display("done: serdes control");
        for (k = 0; k < 4; k++) begin
            v = ($urandom & 16'hf811) | (k << 2);
            mk = (k == 1) ? 2'h0 : k[1:0];
            {sdi, gout, goe, ffl} <= $urandom;
            wr(8'h4c, v);
            rd(8'h4c, v);
            chk({ledm, mdi, sdo, pin_o, pin_oe}, {v[15:12], mk,
                sdi ^ {4{v[0]}}, v[4] ? {ffl, 1'b1} : {gout, goe}});
        end
        blinks(16'h0000);
        chk(nb, 1);
        blinks(16'h0800);
        chk(nb, 0);
        $display("done: extended mode");
        n = 1 + $urandom % 20;
        pulse(n);
        rd(8'h48, 32'h8000 | n);
        rd(8'h48, 0);
        pulse(10001);
        rd(8'h48, 32'h8001);
        fef <= 1'b1;
        @(posedge clk);
        fef <= 1'b0;
        rd(8'h40, 32'hc340);
        rd(8'h40, 32'hc300);
        rd(8'h80, 32'h7);
        wr(8'h84, 16'h0001);
        chk(dut.o_irq, 1);
        wr(8'h80, 16'h0001);
        chk(dut.o_irq, 0);
        rd(8'h80, 32'h6);
        $display("done: counters and events");
        wr(8'h7c, 16'h0000);
        chk(pg, 0);
        wr(8'h40, 16'h1234);
        rd(8'h40, 32'h1234);
        wr(8'h7c, 16'h0001);
        rd(8'h40, 32'hc300);
        wr(8'h08, 16'h5a5a);
        rd(8'h08, 32'h5a5a);
        wr(8'h88, 16'h0000);
        rd(8'h88, 32'h1);
        rd(8'h90, 0);
        $display("done: paging");
        report_and_stop();
    end
endmodule
